/* rtl/slsp_panel.sv */
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
module slsp_panel #(
    parameter int HALF_BLINK = slsp_pkg::HALF_BLINK_CYC,
    parameter int HOLD = slsp_pkg::HOLD_CYC,
    parameter int GAP = slsp_pkg::GAP_CYC,
    parameter int REBOOT = slsp_pkg::REBOOT_CYC,
    parameter int DEBOUNCE = slsp_pkg::DEBOUNCE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire slsp_pkg::slsp_status_t status,
    input wire slsp_pkg::slsp_event_t events,
    input wire logic loadSwitchPin,
    input wire logic runStopSwitchPin,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output slsp_pkg::slsp_leds_t leds,
    output logic runMode,
    output logic eraseAllPulse,
    output logic rebootPulse,
    output logic [31:0] regRdData,
    output logic irq
);
    localparam logic [31:0] OFS_STATUS = 32'h0;
    localparam logic [31:0] OFS_CLEAR = 32'h4;
    localparam logic [31:0] OFS_ENABLE = 32'h8;
    localparam logic [31:0] OFS_STATE = 32'hC;
    localparam int NEV = 4;
    localparam int TW = $clog2(REBOOT + HOLD + GAP + 2);
    localparam int BW = $clog2(HALF_BLINK + 1);

    // Switch conditioning
    logic loadPressed, runPressed, bothRaw;
    slsp_switch_hold #(.DEBOUNCE(DEBOUNCE), .HOLD(HOLD)) uRunHold (
        .sys_clk, .rst, .clkEn,
        .pinPressed(runStopSwitchPin),
        .pressed(runPressed),
        .heldPulse()
    );
    slsp_switch_hold #(.DEBOUNCE(DEBOUNCE), .HOLD(HOLD)) uLoadHold (
        .sys_clk, .rst, .clkEn,
        .pinPressed(loadSwitchPin),
        .pressed(loadPressed),
        .heldPulse()
    );
    assign bothRaw = loadPressed & runPressed;

    // Status inputs are same-clock logic; register once for clean edges
    slsp_pkg::slsp_status_t st_reg;
    slsp_pkg::slsp_event_t ev_reg;

    // Hold timers for the two switch gestures
    logic [TW-1:0] runT_reg, runT_next, bothT_reg, bothT_next;
    logic runDone_reg, runDone_next, bothDone_reg, bothDone_next;
    logic runMode_reg, runMode_next, erase_reg, erase_next;

    always_comb begin
        runT_next = runT_reg;
        bothT_next = bothT_reg;
        runDone_next = runDone_reg;
        bothDone_next = bothDone_reg;
        runMode_next = runMode_reg;
        erase_next = 1'b0;
        // Two-switch gesture: erase all
        if (!bothRaw || !st_reg.bootDone) begin
            bothT_next = '0;
            bothDone_next = 1'b0;
        end else if (!bothDone_reg) begin
            if (bothT_reg >= TW'(HOLD - 1)) begin
                erase_next = 1'b1;
                bothDone_next = 1'b1;
            end else begin
                bothT_next = bothT_reg + TW'(1);
            end
        end
        // Run/stop gesture alone; pressing the load switch with it cancels it until run/stop is released
        if (!runPressed || loadPressed || !st_reg.bootDone) begin
            runT_next = '0;
            runDone_next = loadPressed & runPressed;
        end else if (!runDone_reg) begin
            if (runT_reg >= TW'(HOLD - 1)) begin
                runMode_next = ~runMode_reg;
                runDone_next = 1'b1;
            end else begin
                runT_next = runT_reg + TW'(1);
            end
        end
    end

    // Blink time base: 1 Hz square wave
    logic [BW-1:0] blinkCnt_reg, blinkCnt_next;
    logic blink_reg, blink_next, halfTick;
    logic cardTog_reg, cardTog_next;
    assign halfTick = (blinkCnt_reg >= BW'(HALF_BLINK - 1));

    always_comb begin
        blinkCnt_next = halfTick ? '0 : blinkCnt_reg + BW'(1);
        blink_next = halfTick ? ~blink_reg : blink_reg;
        cardTog_next = (st_reg.cardLoading && halfTick) ? ~cardTog_reg : cardTog_reg;
    end

    // Display sequencer
    slsp_pkg::slsp_show_t show_reg, show_next;
    logic [2:0] flashN_reg, flashN_next, flashDone_reg, flashDone_next;
    logic [TW-1:0] tmr_reg, tmr_next;
    logic inGap_reg, inGap_next, reboot_reg, reboot_next;
    logic [2:0] faultCount;

    // Fault code, lowest count taking priority
    always_comb begin
        faultCount = 3'h0;
        if (ev_reg.faultFileMissing) faultCount = slsp_pkg::FLASH_FILE_MISSING;
        if (ev_reg.faultAddrTextBad) faultCount = slsp_pkg::FLASH_ADDR_TEXT_BAD;
        if (ev_reg.faultAddrCorrupt) faultCount = slsp_pkg::FLASH_ADDR_CORRUPT;
        if (ev_reg.faultAddrEmpty) faultCount = slsp_pkg::FLASH_ADDR_EMPTY;
    end

    always_comb begin
        show_next = show_reg;
        flashN_next = flashN_reg;
        flashDone_next = flashDone_reg;
        tmr_next = tmr_reg;
        inGap_next = inGap_reg;
        reboot_next = 1'b0;
        case (show_reg)
            slsp_pkg::SLSP_SHOW_NORMAL: begin
                if (faultCount != 3'h0) begin
                    show_next = slsp_pkg::SLSP_SHOW_FAULT;
                    flashN_next = faultCount;
                    flashDone_next = 3'h0;
                    inGap_next = 1'b0;
                    tmr_next = '0;
                end else if (ev_reg.dlActive) begin
                    show_next = slsp_pkg::SLSP_SHOW_DOWNLOAD;
                end
            end
            slsp_pkg::SLSP_SHOW_DOWNLOAD: begin
                if (ev_reg.dlFail) begin
                    show_next = slsp_pkg::SLSP_SHOW_DL_FAIL;
                    flashN_next = ev_reg.dlErrCount;
                    flashDone_next = 3'h0;
                    inGap_next = 1'b0;
                    tmr_next = '0;
                end else if (ev_reg.dlDone) begin
                    show_next = slsp_pkg::SLSP_SHOW_REBOOT;
                    tmr_next = '0;
                end else if (!ev_reg.dlActive) begin
                    show_next = slsp_pkg::SLSP_SHOW_NORMAL;
                end
            end
            slsp_pkg::SLSP_SHOW_REBOOT: begin
                if (tmr_reg >= TW'(REBOOT - 1)) begin
                    reboot_next = 1'b1;
                    show_next = slsp_pkg::SLSP_SHOW_NORMAL;
                end else begin
                    tmr_next = tmr_reg + TW'(1);
                end
            end
            slsp_pkg::SLSP_SHOW_DL_FAIL, slsp_pkg::SLSP_SHOW_FAULT: begin
                // Burst of flashN flashes, then a dark gap, repeating
                if (show_reg == slsp_pkg::SLSP_SHOW_FAULT && faultCount == 3'h0) begin
                    show_next = slsp_pkg::SLSP_SHOW_NORMAL;
                end else if (show_reg == slsp_pkg::SLSP_SHOW_DL_FAIL && ev_reg.dlActive
                             && !ev_reg.dlFail) begin
                    show_next = slsp_pkg::SLSP_SHOW_DOWNLOAD;
                end else if (inGap_reg) begin
                    if (tmr_reg >= TW'(GAP - 1)) begin
                        inGap_next = 1'b0;
                        tmr_next = '0;
                        flashDone_next = 3'h0;
                    end else begin
                        tmr_next = tmr_reg + TW'(1);
                    end
                end else if (halfTick && blink_reg) begin
                    // End of one lit half: one flash complete
                    if (flashDone_reg + 3'h1 >= flashN_reg) begin
                        inGap_next = 1'b1;
                        tmr_next = '0;
                    end
                    flashDone_next = flashDone_reg + 3'h1;
                end
            end
            default: show_next = slsp_pkg::SLSP_SHOW_NORMAL;
        endcase
    end

    // Indicator outputs
    slsp_pkg::slsp_leds_t leds_reg, leds_next;
    logic burstLit;
    assign burstLit = !inGap_reg && blink_reg;

    always_comb begin
        leds_next = leds_reg;
        if (!st_reg.selfTestPass) leds_next.selfTestLed = 1'b0;
        else if (st_reg.cardLoading) leds_next.selfTestLed = cardTog_reg;
        else if (st_reg.forcingOn) leds_next.selfTestLed = blink_reg;
        else leds_next.selfTestLed = 1'b1;
        leds_next.modeLed = runMode_reg;
        case (show_reg)
            slsp_pkg::SLSP_SHOW_DOWNLOAD: begin
                leds_next.selfTestLed = blink_reg;
                leds_next.modeLed = ~blink_reg;
            end
            slsp_pkg::SLSP_SHOW_REBOOT: begin
                leds_next.selfTestLed = 1'b0;
                leds_next.modeLed = 1'b0;
            end
            slsp_pkg::SLSP_SHOW_DL_FAIL, slsp_pkg::SLSP_SHOW_FAULT: begin
                leds_next.selfTestLed = burstLit;
                leds_next.modeLed = burstLit;
            end
            default: ;
        endcase
        if (st_reg.ladderIllegal || st_reg.ladderCrcError)
            leds_next.moduleHealthIndicator = slsp_pkg::SLSP_COL_WHITE;
        else if (st_reg.rtcFault || st_reg.ioCfgError)
            leds_next.moduleHealthIndicator = slsp_pkg::SLSP_COL_RED;
        else
            leds_next.moduleHealthIndicator = slsp_pkg::SLSP_COL_GREEN;
        if (st_reg.netIllegalId || st_reg.netDuplicateId || st_reg.netNoResponse)
            leds_next.networkHealthIndicator = slsp_pkg::SLSP_COL_RED;
        else
            leds_next.networkHealthIndicator = slsp_pkg::SLSP_COL_GREEN;
    end

    // Interrupt status: run toggle, erase, reboot, fault entry
    logic [NEV-1:0] evBits, irqSt_reg, irqSt_next, irqEn_reg, irqEn_next, clr;
    logic [31:0] rd_reg, rd_next;
    logic irq_reg;
    assign evBits = {show_next == slsp_pkg::SLSP_SHOW_FAULT &&
                     show_reg != slsp_pkg::SLSP_SHOW_FAULT,
                     reboot_next, erase_next, runMode_next != runMode_reg};
    assign clr = (regWrite && regAddr == OFS_CLEAR) ? regWrData[NEV-1:0] : '0;

    // Set beats clear; register reads
    always_comb begin
        irqSt_next = (irqSt_reg & ~clr) | evBits;
        irqEn_next = (regWrite && regAddr == OFS_ENABLE) ? regWrData[NEV-1:0] : irqEn_reg;
        rd_next = '0;
        if (regRead) begin
            case (regAddr)
                OFS_STATUS: rd_next = 32'(irqSt_reg);
                OFS_ENABLE: rd_next = 32'(irqEn_reg);
                OFS_STATE: rd_next = {27'h0, show_reg, bothRaw, runMode_reg};
                default: rd_next = '0;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            ev_reg <= '0;
            runT_reg <= '0;
            bothT_reg <= '0;
            runDone_reg <= 1'b0;
            bothDone_reg <= 1'b0;
            runMode_reg <= 1'b0;
            erase_reg <= 1'b0;
            blinkCnt_reg <= '0;
            blink_reg <= 1'b0;
            cardTog_reg <= 1'b0;
            show_reg <= slsp_pkg::SLSP_SHOW_NORMAL;
            flashN_reg <= 3'h0;
            flashDone_reg <= 3'h0;
            tmr_reg <= '0;
            inGap_reg <= 1'b0;
            reboot_reg <= 1'b0;
            leds_reg <= '0;
            irqSt_reg <= '0;
            irqEn_reg <= '0;
            rd_reg <= '0;
            irq_reg <= 1'b0;
        end else if (clkEn) begin
            st_reg <= status;
            ev_reg <= events;
            runT_reg <= runT_next;
            bothT_reg <= bothT_next;
            runDone_reg <= runDone_next;
            bothDone_reg <= bothDone_next;
            runMode_reg <= runMode_next;
            erase_reg <= erase_next;
            blinkCnt_reg <= blinkCnt_next;
            blink_reg <= blink_next;
            cardTog_reg <= cardTog_next;
            show_reg <= show_next;
            flashN_reg <= flashN_next;
            flashDone_reg <= flashDone_next;
            tmr_reg <= tmr_next;
            inGap_reg <= inGap_next;
            reboot_reg <= reboot_next;
            leds_reg <= leds_next;
            irqSt_reg <= irqSt_next;
            irqEn_reg <= irqEn_next;
            rd_reg <= rd_next;
            irq_reg <= |(irqSt_next & irqEn_next);
        end
    end

    assign leds = leds_reg;
    assign runMode = runMode_reg;
    assign eraseAllPulse = erase_reg;
    assign rebootPulse = reboot_reg;
    assign regRdData = rd_reg;
    assign irq = irq_reg;
endmodule

/* rtl/slsp_pkg.sv */
package slsp_pkg;

    // Clock rate and derived timing
    localparam int CLK_HZ = 25000000;
    localparam int BLINK_HZ = 1;
    localparam int HALF_BLINK_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam int HOLD_SEC = 3;
    localparam int HOLD_CYC = HOLD_SEC * CLK_HZ;
    localparam int GAP_SEC = 2;
    localparam int GAP_CYC = GAP_SEC * CLK_HZ;
    localparam int REBOOT_SEC = 30;
    localparam int REBOOT_CYC = REBOOT_SEC * CLK_HZ;
    localparam int DEBOUNCE_US = 10000;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);

    // Fault flash counts
    localparam logic [2:0] FLASH_ADDR_EMPTY = 3'h2;
    localparam logic [2:0] FLASH_ADDR_CORRUPT = 3'h3;
    localparam logic [2:0] FLASH_ADDR_TEXT_BAD = 3'h4;
    localparam logic [2:0] FLASH_FILE_MISSING = 3'h5;

    // Colour codes of the health indicators
    typedef enum logic [1:0] {
        SLSP_COL_OFF = 2'b00,
        SLSP_COL_GREEN = 2'b01,
        SLSP_COL_RED = 2'b10,
        SLSP_COL_WHITE = 2'b11
    } slsp_colour_t;

    // Status conditions reported by firmware
    typedef struct packed {
        logic selfTestDone;
        logic selfTestPass;
        logic forcingOn;
        logic cardLoading;
        logic rtcFault;
        logic ioCfgError;
        logic ladderIllegal;
        logic ladderCrcError;
        logic netIllegalId;
        logic netDuplicateId;
        logic netNoResponse;
        logic bootDone;
    } slsp_status_t;

    // Download progress and diagnostic faults
    typedef struct packed {
        logic dlActive;
        logic dlFail;
        logic dlDone;
        logic [2:0] dlErrCount;
        logic faultAddrEmpty;
        logic faultAddrCorrupt;
        logic faultAddrTextBad;
        logic faultFileMissing;
    } slsp_event_t;

    // Indicator drive
    typedef struct packed {
        logic selfTestLed;
        logic modeLed;
        slsp_colour_t moduleHealthIndicator;
        slsp_colour_t networkHealthIndicator;
    } slsp_leds_t;

    // Display state machine
    typedef enum logic [2:0] {
        SLSP_SHOW_NORMAL = 3'b000,
        SLSP_SHOW_DOWNLOAD = 3'b001,
        SLSP_SHOW_DL_FAIL = 3'b010,
        SLSP_SHOW_REBOOT = 3'b011,
        SLSP_SHOW_FAULT = 3'b100
    } slsp_show_t;

endpackage

/* rtl/slsp_switch_hold.sv */
`timescale 1ns/100ps
// Synced, debounced switch; one pulse per press held HOLD cycles
module slsp_switch_hold #(
    parameter int DEBOUNCE = slsp_pkg::DEBOUNCE_CYC,
    parameter int HOLD = slsp_pkg::HOLD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic pinPressed,
    output logic pressed,
    output logic heldPulse
);
    localparam int CW = $clog2(HOLD + DEBOUNCE + 2);

    logic sync1_reg, sync2_reg;
    logic stable_reg, stable_next;
    logic [CW-1:0] deb_reg, deb_next;
    logic [CW-1:0] hold_reg, hold_next;
    logic fired_reg, fired_next;
    logic pulse_reg, pulse_next;

    // Debounce and hold timing, acting once per continuous press
    always_comb begin
        stable_next = stable_reg;
        deb_next = deb_reg;
        hold_next = hold_reg;
        fired_next = fired_reg;
        pulse_next = 1'b0;
        if (sync2_reg != stable_reg) begin
            if (deb_reg >= CW'(DEBOUNCE - 1)) begin
                stable_next = sync2_reg;
                deb_next = '0;
            end else begin
                deb_next = deb_reg + CW'(1);
            end
        end else begin
            deb_next = '0;
        end
        if (!stable_reg) begin
            hold_next = '0;
            fired_next = 1'b0;
        end else if (!fired_reg) begin
            if (hold_reg >= CW'(HOLD - 1)) begin
                pulse_next = 1'b1;
                fired_next = 1'b1;
            end else begin
                hold_next = hold_reg + CW'(1);
            end
        end
    end

    // Registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            stable_reg <= 1'b0;
            deb_reg <= '0;
            hold_reg <= '0;
            fired_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else if (clkEn) begin
            sync1_reg <= pinPressed;
            sync2_reg <= sync1_reg;
            stable_reg <= stable_next;
            deb_reg <= deb_next;
            hold_reg <= hold_next;
            fired_reg <= fired_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pressed = stable_reg;
    assign heldPulse = pulse_reg;
endmodule

/* testbench/slsp_operator_model.sv */
`timescale 1ns/100ps
// Operator at the panel: presses switches and counts lamp flashes
module slsp_operator_model #(
    parameter int DARK_MIN = 6
) (
    input wire logic sys_clk,
    input wire slsp_pkg::slsp_leds_t leds,
    output logic loadSwitchPin,
    output logic runStopSwitchPin
);
    int dark = 0, rises = 0, lastBurst = 0, lastGap = 0, apart = 0;
    initial {loadSwitchPin, runStopSwitchPin} = 2'b00;
    // Press switches n cycles
    task automatic hold(input logic load, input logic run, input int n);
        @(posedge sys_clk);
        loadSwitchPin <= load;
        runStopSwitchPin <= run;
        repeat (n) @(posedge sys_clk);
        loadSwitchPin <= 1'b0;
        runStopSwitchPin <= 1'b0;
    endtask
    // A burst ends once the lamps stay dark longer than a blink gap
    always @(posedge sys_clk) begin
        if (leds.selfTestLed !== leds.modeLed) apart <= apart + 1;
        if (leds.selfTestLed) begin
            if (dark > DARK_MIN) lastGap <= dark;
            if (dark != 0) rises <= rises + 1;
            dark <= 0;
        end else begin
            if (dark == DARK_MIN) begin
                lastBurst <= rises;
                rises <= 0;
            end
            dark <= dark + 1;
        end
    end
endmodule

/* testbench/slsp_panel_assertions.sv */
`timescale 1ns/100ps
// Port-level checks of the panel
module slsp_panel_assertions #(
    parameter int HALF_BLINK = 4,
    parameter int HOLD = 20,
    parameter int GAP = 10,
    parameter int REBOOT = 30
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire slsp_pkg::slsp_status_t status,
    input wire slsp_pkg::slsp_event_t events,
    input wire logic loadSwitchPin,
    input wire logic runStopSwitchPin,
    input wire logic [31:0] regAddr,
    input wire logic regRead,
    input wire slsp_pkg::slsp_leds_t leds,
    input wire logic runMode,
    input wire logic eraseAllPulse,
    input wire logic rebootPulse,
    input wire logic [31:0] regRdData
);
    localparam int QUIET = REBOOT + GAP + 12 * HALF_BLINK + 8;
    int runHeld, bothHeld, quiet;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Lengths of continuous presses and of calm input periods
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            runHeld <= 0;
            bothHeld <= 0;
            quiet <= 0;
        end else begin
            runHeld <= runStopSwitchPin ? runHeld + 1 : 0;
            bothHeld <= (runStopSwitchPin && loadSwitchPin) ? bothHeld + 1 : 0;
            quiet <= (events == '0 && $stable(status)) ? quiet + 1 : 0;
        end
    end
    // Causes of each module colour and of the network red colour
    sequence modRed;
        clkEn && (status.rtcFault || status.ioCfgError) && !status.ladderIllegal
            && !status.ladderCrcError;
    endsequence
    sequence modWhite;
        clkEn && (status.ladderIllegal || status.ladderCrcError);
    endsequence
    sequence modGood;
        clkEn && !(status.rtcFault || status.ioCfgError || status.ladderIllegal
            || status.ladderCrcError);
    endsequence
    sequence netBad;
        clkEn && (status.netIllegalId || status.netDuplicateId || status.netNoResponse);
    endsequence
    AST_MOD_RED: assert property (
        modRed [*4] |-> leds.moduleHealthIndicator == slsp_pkg::SLSP_COL_RED)
        else $error("module colour not red");
    AST_MOD_GREEN: assert property (
        modGood [*4] |-> leds.moduleHealthIndicator == slsp_pkg::SLSP_COL_GREEN)
        else $error("module colour not green");
    AST_MOD_WHITE: assert property (
        modWhite [*4] |-> leds.moduleHealthIndicator == slsp_pkg::SLSP_COL_WHITE)
        else $error("module colour not white");
    AST_NET_RED: assert property (
        netBad [*4] |-> leds.networkHealthIndicator == slsp_pkg::SLSP_COL_RED)
        else $error("network colour not red");
    AST_SELFTEST_STEADY: assert property (
        quiet >= QUIET && status.selfTestDone && !status.forcingOn && !status.cardLoading
        |-> leds.selfTestLed == status.selfTestPass) else $error("self-test lamp wrong");
    AST_RUN_TOGGLE_HOLD: assert property (
        $changed(runMode) |-> runHeld >= HOLD) else $error("run toggled without full hold");
    AST_ERASE_HOLD: assert property (
        eraseAllPulse |-> bothHeld >= HOLD) else $error("erase without full hold");
    AST_ERASE_ONCE: assert property (
        eraseAllPulse |=> !eraseAllPulse) else $error("erase pulse too long");
    AST_REBOOT_ONCE: assert property (
        rebootPulse |=> !rebootPulse) else $error("reboot pulse too long");
    AST_READ_IDLE_ZERO: assert property (
        !(regRead && clkEn && regAddr <= 32'hC) |=> regRdData == '0)
        else $error("read data not zero outside read");
endmodule

bind slsp_panel slsp_panel_assertions #(.HALF_BLINK(HALF_BLINK), .HOLD(HOLD), .GAP(GAP),
    .REBOOT(REBOOT)) u_slsp_chk (.sys_clk, .rst, .clkEn, .status, .events, .loadSwitchPin,
    .runStopSwitchPin, .regAddr, .regRead, .leds, .runMode, .eraseAllPulse, .rebootPulse,
    .regRdData);

/* testbench/tb.sv */
`timescale 1ns/100ps
// Front-panel bench
module tb;
    localparam int HB = 4, HOLD = 20, GAP = 10, REBOOT = 30;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    slsp_pkg::slsp_status_t status = '0;
    slsp_pkg::slsp_event_t events = '0;
    logic loadSwitchPin, runStopSwitchPin, regWrite = 1'b0, regRead = 1'b0;
    logic [31:0] regAddr = '0, regWrData = '0, regRdData;
    slsp_pkg::slsp_leds_t leds;
    logic runMode, eraseAllPulse, rebootPulse, irq;
    // Per step, lowest first: fault bits 7..0 of status; module colour green,red,red,white,white,green
    logic [47:0] faultSet = 48'h0010_A244_8800;
    logic [11:0] modCol = 12'h7E9;
    int miscompares = 0, checked = 0, erases = 0, n, i, a;
    always #20 sys_clk = ~sys_clk;
    slsp_panel #(.HALF_BLINK(HB), .HOLD(HOLD), .GAP(GAP), .REBOOT(REBOOT), .DEBOUNCE(2)) dut (
        .sys_clk, .rst, .clkEn, .status, .events, .loadSwitchPin, .runStopSwitchPin,
        .regAddr, .regWrData, .regWrite, .regRead, .leds, .runMode, .eraseAllPulse,
        .rebootPulse, .regRdData, .irq);
    slsp_operator_model op (.sys_clk, .leds, .loadSwitchPin, .runStopSwitchPin);
    // Counts erase pulses
    always @(posedge sys_clk) begin
        if (eraseAllPulse === 1'b1) erases <= erases + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= ad;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] ad, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 chk(regRdData, exp, what);
    endtask
    // Lamp changes over eight half blinks
    task automatic count_changes(output int c);
        logic prev;
        c = 0;
        prev = leds.selfTestLed;
        repeat (8 * HB) begin
            @(posedge sys_clk);
            #1 if (leds.selfTestLed !== prev) c++;
            prev = leds.selfTestLed;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #(40 * 20000);
        miscompares++;
        report_and_stop();
    end
    initial begin
        status.selfTestDone <= 1'b1;
        status.selfTestPass <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(32'h8, 32'h0, "enable reset");
        wr(32'h8, 32'h5);
        wr(32'h10, 32'hF);
        rd(32'h8, 32'h5, "enable readback");
        rd(32'h10, 32'h0, "unmapped read");
        $display("test registers done");
        for (i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            status[7:0] <= faultSet[8*i+:8];
            repeat (5) @(posedge sys_clk);
            #1 chk(leds.moduleHealthIndicator, modCol[2*i+:2], "module colour");
            chk(leds.networkHealthIndicator, (i == 1 || i == 2 || i == 3) ?
                slsp_pkg::SLSP_COL_RED : slsp_pkg::SLSP_COL_GREEN, "network colour");
        end
        $display("test colours done");
        repeat (110) @(posedge sys_clk);
        #1 chk(leds.selfTestLed, 1'b1, "self-test pass lamp");
        @(posedge sys_clk);
        status.forcingOn <= 1'b1;
        repeat (10) @(posedge sys_clk);
        count_changes(n);
        chk(n, 8, "forcing blink changes");
        @(posedge sys_clk);
        status.forcingOn <= 1'b0;
        status.cardLoading <= 1'b1;
        repeat (10) @(posedge sys_clk);
        count_changes(n);
        chk(n > 0, 1'b1, "card load toggling");
        @(posedge sys_clk);
        status.cardLoading <= 1'b0;
        status.selfTestPass <= 1'b0;
        repeat (110) @(posedge sys_clk);
        #1 chk(leds.selfTestLed, 1'b0, "self-test fail lamp");
        $display("test self-test lamp done");
        @(posedge sys_clk);
        events.dlActive <= 1'b1;
        repeat (10) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk) #1 chk(leds.selfTestLed ^ leds.modeLed, 1'b1,
            "download alternation");
        @(posedge sys_clk);
        events.dlFail <= 1'b1;
        events.dlErrCount <= 3'h3;
        repeat (6) @(posedge sys_clk);
        a = op.apart;
        repeat (60) @(posedge sys_clk);
        chk(op.lastBurst, 3, "download error flashes");
        chk(op.apart - a, 0, "download fail together");
        events.dlFail <= 1'b0;
        events.dlDone <= 1'b1;
        n = 0;
        while (rebootPulse !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk(n >= REBOOT && n <= REBOOT + 6, 1'b1, "reboot delay");
        @(posedge sys_clk);
        events <= '0;
        repeat (REBOOT + 20) @(posedge sys_clk);
        $display("test download done");
        for (i = 0; i < 4; i++) begin
            events <= slsp_pkg::slsp_event_t'(10'h008 >> i);
            repeat (20) @(posedge sys_clk);
            a = op.apart;
            repeat (130) @(posedge sys_clk);
            chk(op.lastBurst, i + 2, "fault flash count");
            chk(op.lastGap >= GAP, 1'b1, "fault dark gap");
            chk(op.apart - a, 0, "fault lamps together");
            events <= '0;
            repeat (60) @(posedge sys_clk);
        end
        $display("test faults done");
        op.hold(1'b0, 1'b1, 70);
        repeat (10) @(posedge sys_clk);
        #1 chk(runMode, 1'b0, "no toggle before boot");
        @(posedge sys_clk);
        status.bootDone <= 1'b1;
        wr(32'h4, 32'hF);
        op.hold(1'b0, 1'b1, HOLD - 5);
        repeat (10) @(posedge sys_clk);
        #1 chk(runMode, 1'b0, "short press ignored");
        op.hold(1'b0, 1'b1, 70);
        repeat (10) @(posedge sys_clk);
        #1 chk(runMode, 1'b1, "run toggle once");
        chk(irq, 1'b1, "irq on toggle");
        rd(32'h0, 32'h1, "status after toggle");
        op.hold(1'b1, 1'b1, 70);
        repeat (10) @(posedge sys_clk);
        #1 chk(erases, 1, "erase once");
        chk(runMode, 1'b1, "no toggle on both");
        rd(32'h0, 32'h3, "status after erase");
        wr(32'h8, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1 chk(irq, 1'b0, "irq masked");
        wr(32'h8, 32'h5);
        repeat (3) @(posedge sys_clk);
        #1 chk(irq, 1'b1, "irq unmasked");
        wr(32'h4, 32'h3);
        repeat (3) @(posedge sys_clk);
        #1 chk(irq, 1'b0, "irq cleared");
        rd(32'h0, 32'h0, "status cleared");
        $display("test switches done");
        report_and_stop();
    end
endmodule
